// ==== reference_clock_output_divider.sv ====
// Operation
// - Enable bit drives divided clock onto pin
// - Divider field selects power-of-two division
// - CPU equals peripheral clock unless doze
// - Output routed to selectable remappable pin
`timescale 1ns/1ns
module reference_clock_output_divider (
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 rst_i,
  input  wire logic [refout_pkg::ADDR_W-1:0]        addr_i,
  input  wire logic [refout_pkg::DATA_W-1:0]        wdata_i,
  input  wire logic                                 wr_i,
  input  wire logic                                 rd_i,
  output logic      [refout_pkg::DATA_W-1:0]        rdata_o,
  input  wire logic                                 crystal_clk_i,
  input  wire logic                                 internal_clk_i,
  input  wire logic                                 sleep_i,
  output logic                                      peripheral_clock_o,
  output logic                                      cpu_instruction_clock_o,
  output logic      [refout_pkg::PIN_COUNT-1:0]     reference_clock_out_pin_o,
  output logic      [refout_pkg::PIN_COUNT-1:0]     reference_clock_out_pin_oe_n_o
);
  logic [refout_pkg::DATA_W-1:0]    control_reg;
  logic [refout_pkg::PIN_SEL_W-1:0] pin_sel_reg;
  logic [refout_pkg::DOZE_W-1:0]    doze_reg;
  logic [2**refout_pkg::DOZE_W-1:0] doze_cnt_reg;
  logic [2**refout_pkg::DOZE_W-1:0] doze_cnt_next;
  logic                             doze_wrap;
  logic                             crystal_lvl;
  logic                             internal_lvl;
  logic                             crystal_q_reg;
  logic                             internal_q_reg;
  logic                             crystal_tick;
  logic                             internal_tick;
  logic                             src_tick;
  logic                             refout_enable;
  logic                             refout_run_in_sleep;
  logic                             refout_source_select;
  logic [refout_pkg::DIV_W-1:0]     refout_divider;
  logic                             run;
  logic                             div_clk;
  logic                             sel_control;
  logic                             sel_pin;
  logic                             sel_doze;
  logic                             sel_status;
  logic [refout_pkg::DATA_W-1:0]    rd_mux;
  logic [refout_pkg::PIN_COUNT-1:0] pin_hit;

  assign refout_enable        = control_reg[refout_pkg::BIT_ENABLE];
  assign refout_run_in_sleep  = control_reg[refout_pkg::BIT_RUN_SLEEP];
  assign refout_source_select = control_reg[refout_pkg::BIT_SRC_SEL];
  assign refout_divider       = control_reg[refout_pkg::DIV_LSB +: refout_pkg::DIV_W];

  refout_sync u_sync_crystal (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (crystal_clk_i),
    .level_o   (crystal_lvl)
  );

  refout_sync u_sync_internal (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (internal_clk_i),
    .level_o   (internal_lvl)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      crystal_q_reg  <= 1'b0;
      internal_q_reg <= 1'b0;
    end else begin
      crystal_q_reg  <= crystal_lvl;
      internal_q_reg <= internal_lvl;
    end
  end

  // Rising edges of the sampled sources become one-cycle ticks
  assign crystal_tick  = crystal_lvl & ~crystal_q_reg;
  assign internal_tick = internal_lvl & ~internal_q_reg;
  assign src_tick      = refout_source_select ? crystal_tick : internal_tick;

  // Sleep stops the output unless run-in-sleep is set
  assign run = refout_enable && (!sleep_i || refout_run_in_sleep);

  refout_pow2_div u_div (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .run_i      (run),
    .src_tick_i (src_tick),
    .div_i      (refout_divider),
    .clk_o      (div_clk)
  );

  // Only the selected pin is driven; the rest stay released
  genvar g;
  generate
    for (g = 0; g < refout_pkg::PIN_COUNT; g++) begin : g_pin
      assign pin_hit[g] = run && (pin_sel_reg == (refout_pkg::PIN_SEL_W)'(g));
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reference_clock_out_pin_o      <= '0;
      reference_clock_out_pin_oe_n_o <= '1;
    end else begin
      reference_clock_out_pin_o      <= pin_hit & {refout_pkg::PIN_COUNT{div_clk}};
      reference_clock_out_pin_oe_n_o <= ~pin_hit;
    end
  end

  // Doze: CPU enable every 2**doze peripheral cycles, peripheral runs each cycle
  assign doze_wrap     = (doze_cnt_reg >= ((2**refout_pkg::DOZE_W)'(1) << doze_reg) - 1'b1);
  assign doze_cnt_next = doze_wrap ? '0 : doze_cnt_reg + 1'b1;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      doze_cnt_reg <= '0;
    end else begin
      doze_cnt_reg <= doze_cnt_next;
    end
  end

  assign peripheral_clock_o      = 1'b1;
  assign cpu_instruction_clock_o = (doze_reg == '0) ? 1'b1 : doze_wrap;

  assign sel_control = (addr_i == refout_pkg::ADDR_CONTROL);
  assign sel_status  = (addr_i == refout_pkg::ADDR_STATUS);
  assign sel_pin     = (addr_i == refout_pkg::ADDR_PIN_SEL);
  assign sel_doze    = (addr_i == refout_pkg::ADDR_DOZE);

  // Divider writes while enabled are not blocked; software must clear enable first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      control_reg <= refout_pkg::CONTROL_RESET;
      pin_sel_reg <= '0;
      doze_reg    <= '0;
    end else if (wr_i) begin
      if (sel_control) begin
        control_reg <= wdata_i & refout_pkg::CONTROL_WMASK;
      end
      if (sel_pin) begin
        pin_sel_reg <= wdata_i[refout_pkg::PIN_SEL_W-1:0];
      end
      if (sel_doze) begin
        doze_reg <= wdata_i[refout_pkg::DOZE_W-1:0];
      end
    end
  end

  assign rd_mux = sel_control ? control_reg :
                  sel_status  ? {14'h0000, div_clk, run} :
                  sel_pin     ? {14'h0000, pin_sel_reg} :
                  sel_doze    ? {13'h0000, doze_reg} :
                  refout_pkg::ZERO16;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= refout_pkg::ZERO16;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= refout_pkg::ZERO16;
    end
  end

  property p_enable_oe;
    @(posedge clk_sys_i) disable iff (rst_i)
      !refout_enable |=> &reference_clock_out_pin_oe_n_o;
  endproperty
  a_enable_oe: assert property (p_enable_oe) else $error("pin driven while disabled");

  property p_sleep_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      (sleep_i && !refout_run_in_sleep) |=> &reference_clock_out_pin_oe_n_o;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("pin driven in sleep");

  property p_one_pin;
    @(posedge clk_sys_i) disable iff (rst_i)
      run |=> !reference_clock_out_pin_oe_n_o[$past(pin_sel_reg)];
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("selected pin not driven");

  property p_div_one;
    @(posedge clk_sys_i) disable iff (rst_i)
      (run && refout_divider == '0 && $stable(refout_divider)) |=> (div_clk == $past(src_tick));
  endproperty
  a_div_one: assert property (p_div_one) else $error("undivided path wrong");

  property p_src;
    @(posedge clk_sys_i) disable iff (rst_i)
      (run && refout_divider == '0 && refout_source_select && crystal_tick) |=> div_clk;
  endproperty
  a_src: assert property (p_src) else $error("crystal source not used");

  property p_doze;
    @(posedge clk_sys_i) disable iff (rst_i)
      (doze_reg == '0) |-> cpu_instruction_clock_o == peripheral_clock_o;
  endproperty
  a_doze: assert property (p_doze) else $error("cpu clock differs without doze");

  property p_reset_idle;
    @(posedge clk_sys_i)
      rst_i |=> (&reference_clock_out_pin_oe_n_o && reference_clock_out_pin_o == '0 &&
                 rdata_o == refout_pkg::ZERO16);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");

  property p_pin_data;
    @(posedge clk_sys_i) disable iff (rst_i)
      run |=> (reference_clock_out_pin_o[$past(pin_sel_reg)] == $past(div_clk));
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pin data differs from divider");

  property p_released_low;
    @(posedge clk_sys_i) disable iff (rst_i)
      (reference_clock_out_pin_o & reference_clock_out_pin_oe_n_o) == '0;
  endproperty
  a_released_low: assert property (p_released_low) else $error("released pin carries data");

  property p_one_oe;
    @(posedge clk_sys_i) disable iff (rst_i)
      $countones(~reference_clock_out_pin_oe_n_o) <= 1;
  endproperty
  a_one_oe: assert property (p_one_oe) else $error("more than one pin driven");

  property p_sleep_run;
    @(posedge clk_sys_i) disable iff (rst_i)
      (refout_enable && sleep_i && refout_run_in_sleep) |=> !reference_clock_out_pin_oe_n_o[$past(pin_sel_reg)];
  endproperty
  a_sleep_run: assert property (p_sleep_run) else $error("pin stopped in sleep");

  property p_stopped_low;
    @(posedge clk_sys_i) disable iff (rst_i)
      !run |=> !div_clk;
  endproperty
  a_stopped_low: assert property (p_stopped_low) else $error("divider runs while stopped");

  property p_div_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      (run && refout_divider != '0 && !src_tick) |=> $stable(div_clk);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divided clock moved without tick");

  property p_div_two;
    @(posedge clk_sys_i) disable iff (rst_i)
      (run && refout_divider == (refout_pkg::DIV_W)'(1) && src_tick) |=> (div_clk != $past(div_clk));
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two did not toggle");

  property p_src_internal;
    @(posedge clk_sys_i) disable iff (rst_i)
      (run && refout_divider == '0 && !refout_source_select && internal_tick) |=> div_clk;
  endproperty
  a_src_internal: assert property (p_src_internal) else $error("internal source not used");

  property p_src_ignored;
    @(posedge clk_sys_i) disable iff (rst_i)
      (run && refout_divider == '0 && refout_source_select && !crystal_tick) |=> !div_clk;
  endproperty
  a_src_ignored: assert property (p_src_ignored) else $error("unselected source leaks");

  property p_cpu_ratio;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cpu_instruction_clock_o && doze_reg != '0) |=> (!cpu_instruction_clock_o || doze_reg != $past(doze_reg));
  endproperty
  a_cpu_ratio: assert property (p_cpu_ratio) else $error("cpu enable too fast in doze");

  property p_doze_half;
    @(posedge clk_sys_i) disable iff (rst_i)
      (doze_reg == (refout_pkg::DOZE_W)'(1) && !cpu_instruction_clock_o) |=>
        (cpu_instruction_clock_o || doze_reg != (refout_pkg::DOZE_W)'(1));
  endproperty
  a_doze_half: assert property (p_doze_half) else $error("cpu enable missing at half rate");

  property p_read_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
      !rd_i |=> (rdata_o == refout_pkg::ZERO16);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

  property p_read_ctrl;
    @(posedge clk_sys_i) disable iff (rst_i)
      (rd_i && sel_control) |=> (rdata_o == $past(control_reg));
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read data wrong");

  property p_status_run;
    @(posedge clk_sys_i) disable iff (rst_i)
      (rd_i && sel_status) |=> (rdata_o[0] == $past(run));
  endproperty
  a_status_run: assert property (p_status_run) else $error("status run bit wrong");

  property p_write_pin;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && sel_pin) |=> (pin_sel_reg == $past(wdata_i[refout_pkg::PIN_SEL_W-1:0]));
  endproperty
  a_write_pin: assert property (p_write_pin) else $error("pin select write lost");

  property p_write_doze;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && sel_doze) |=> (doze_reg == $past(wdata_i[refout_pkg::DOZE_W-1:0]));
  endproperty
  a_write_doze: assert property (p_write_doze) else $error("doze write lost");

  property p_unmapped;
    @(posedge clk_sys_i) disable iff (rst_i)
      (rd_i && !(sel_control || sel_status || sel_pin || sel_doze)) |=> (rdata_o == refout_pkg::ZERO16);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      (control_reg & ~refout_pkg::CONTROL_WMASK) == refout_pkg::ZERO16;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bit set");
endmodule // reference_clock_output_divider

// ==== reference_clock_output_divider_tb_top.sv ====
`timescale 1ns/1ns
module reference_clock_output_divider_tb_top;
  logic        clk_sys_i = 0;
  logic        rst_i     = 1;
  logic        wr_i      = 0;
  logic        rd_i      = 0;
  logic        xtal      = 0;
  logic        intl      = 0;
  logic        sleep_i   = 0;
  logic        clear     = 1;
  logic [3:0]  addr_i    = 4'h0;
  logic [15:0] wdata_i   = 16'h0000;
  logic [15:0] rdata_o;
  logic        periph;
  logic        cpu;
  logic [3:0]  pin;
  logic [3:0]  oe_n;
  int          edges;
  int          err_count = 0;
  int          cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  always #50 xtal = ~xtal;
  always #40 intl = ~intl;
  reference_clock_output_divider reference_clock_output_divider_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .crystal_clk_i(xtal),
    .internal_clk_i(intl), .sleep_i(sleep_i), .peripheral_clock_o(periph), .cpu_instruction_clock_o(cpu),
    .reference_clock_out_pin_o(pin), .reference_clock_out_pin_oe_n_o(oe_n));
  refout_sink refout_sink_inst (.clk_sys_i(clk_sys_i), .clear_i(clear), .pin_i(pin), .oe_n_i(oe_n),
    .sel_i(2'h2), .edges_o(edges));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(name, exp, rdata_o);
  endtask
  task automatic count_edges(input logic [15:0] ctl, input int exp, input string name);
    wr(refout_pkg::ADDR_CONTROL, 16'h0000);
    wr(refout_pkg::ADDR_CONTROL, ctl & 16'h7FFF);
    wr(refout_pkg::ADDR_CONTROL, ctl);
    repeat (20) @(posedge clk_sys_i);
    clear <= 1'b1;
    @(posedge clk_sys_i);
    clear <= 1'b0;
    repeat (640) @(posedge clk_sys_i);
    #1 cmp_count++;
    if (edges < exp - 1 || edges > exp + 1) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, edges);
    end
  endtask
  task automatic test_regs();
    rd(refout_pkg::ADDR_CONTROL, 16'h0000, "control reset");
    chk("oe_n reset", 16'h000F, {12'h000, oe_n});
    wr(refout_pkg::ADDR_CONTROL, 16'h7FFF);
    rd(refout_pkg::ADDR_CONTROL, 16'h3F00, "control mask");
    wr(refout_pkg::ADDR_CONTROL, 16'h0000);
    rd(4'hF, 16'h0000, "unmapped");
    wr(refout_pkg::ADDR_PIN_SEL, 16'h0002);
    rd(refout_pkg::ADDR_PIN_SEL, 16'h0002, "pin select");
    @(posedge clk_sys_i);
    #1 chk("rdata idle", 16'h0000, rdata_o);
    $display("test regs done");
  endtask
  task automatic test_enable();
    wr(refout_pkg::ADDR_CONTROL, 16'h8000);
    repeat (8) @(posedge clk_sys_i);
    chk("oe_n on", 16'h000B, {12'h000, oe_n});
    wr(refout_pkg::ADDR_PIN_SEL, 16'h0001);
    repeat (4) @(posedge clk_sys_i);
    chk("oe_n pin 1", 16'h000D, {12'h000, oe_n});
    wr(refout_pkg::ADDR_PIN_SEL, 16'h0002);
    wr(refout_pkg::ADDR_CONTROL, 16'h0000);
    repeat (8) @(posedge clk_sys_i);
    chk("oe_n off", 16'h000F, {12'h000, oe_n});
    $display("test enable done");
  endtask
  task automatic test_divide();
    count_edges(16'h8000, 80, "div 1");
    count_edges(16'h8100, 40, "div 2");
    count_edges(16'h8300, 10, "div 8");
    count_edges(16'h9000, 64, "crystal div 1");
    count_edges(16'h9200, 16, "crystal div 4");
    $display("test divide done");
  endtask
  task automatic test_sleep();
    sleep_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk("sleep off", 16'h000F, {12'h000, oe_n});
    rd(refout_pkg::ADDR_STATUS, 16'h0000, "status asleep");
    wr(refout_pkg::ADDR_CONTROL, 16'h3200);
    wr(refout_pkg::ADDR_CONTROL, 16'hB200);
    repeat (8) @(posedge clk_sys_i);
    chk("sleep run", 16'h000B, {12'h000, oe_n});
    sleep_i <= 1'b0;
    wr(refout_pkg::ADDR_CONTROL, 16'h0000);
    $display("test sleep done");
  endtask
  task automatic test_doze();
    int c;
    int p;
    for (int d = 0; d < 8; d++) begin
      wr(refout_pkg::ADDR_DOZE, 16'(d));
      c = 0;
      p = 0;
      repeat (256) begin
        @(posedge clk_sys_i);
        #1 c += (cpu === 1'b1);
        p += (periph === 1'b1);
      end
      chk("cpu pulses", 16'(256 >> d), 16'(c));
      chk("periph pulses", 16'h0100, 16'(p));
    end
    $display("test doze done");
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #900000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    test_regs();
    test_enable();
    test_divide();
    test_sleep();
    test_doze();
    conclude();
  end
endmodule // reference_clock_output_divider_tb_top

// ==== refout_pkg.sv ====
package refout_pkg;
  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_PIN_SEL    = 4'h2;
  localparam logic [3:0]  ADDR_DOZE       = 4'h3;
  localparam int          BIT_ENABLE      = 15;
  localparam int          BIT_RUN_SLEEP   = 13;
  localparam int          BIT_SRC_SEL     = 12;
  localparam int          DIV_LSB         = 8;
  localparam int          DIV_W           = 4;
  localparam int          DIV_CNT_W       = 15;
  localparam int          PIN_COUNT       = 4;
  localparam int          PIN_SEL_W       = 2;
  localparam int          DOZE_W          = 3;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [15:0] CONTROL_WMASK   = 16'hBF00;
  localparam logic [15:0] ZERO16          = 16'h0000;
endpackage

// ==== refout_pow2_div.sv ====
`timescale 1ns/1ns
module refout_pow2_div (
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_i,
  input  wire logic                            run_i,
  input  wire logic                            src_tick_i,
  input  wire logic [refout_pkg::DIV_W-1:0]    div_i,
  output logic                                 clk_o
);
  logic [refout_pkg::DIV_CNT_W-1:0] cnt_reg;
  logic [refout_pkg::DIV_CNT_W-1:0] cnt_next;
  logic                             half_done;
  logic [refout_pkg::DIV_CNT_W:0]   half_len;

  // Divide by 2**div: toggle every 2**(div-1) source ticks, code 0 passes the source
  assign half_len  = (refout_pkg::DIV_CNT_W+1)'(1) << (div_i - 1'b1);
  assign half_done = ({1'b0, cnt_reg} + (refout_pkg::DIV_CNT_W+1)'(1)) >= half_len;
  assign cnt_next  = half_done ? '0 : cnt_reg + 1'b1;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= '0;
      clk_o   <= 1'b0;
    end else if (div_i == '0) begin
      clk_o <= src_tick_i;
    end else if (src_tick_i) begin
      cnt_reg <= cnt_next;
      if (half_done) begin
        clk_o <= ~clk_o;
      end
    end
  end
endmodule // refout_pow2_div

// ==== refout_sink.sv ====
`timescale 1ns/1ns
module refout_sink (
  input  wire logic       clk_sys_i,
  input  wire logic       clear_i,
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] oe_n_i,
  input  wire logic [1:0] sel_i,
  output int              edges_o
);
  // Board pull-down holds the line low while the pin is released
  wire logic line_w = (oe_n_i[sel_i] === 1'b0) ? pin_i[sel_i] : 1'b0;
  logic      line_reg = 1'b0;
  always @(posedge clk_sys_i) begin
    line_reg <= line_w;
    if (clear_i) begin
      edges_o <= 0;
    end else if (line_w && !line_reg) begin
      edges_o <= edges_o + 1;
    end
  end
endmodule // refout_sink

// ==== refout_sync.sv ====
`timescale 1ns/1ns
module refout_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Level changes only once the second and third stages agree
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule // refout_sync
